// ===== hdl/program_memory_table_access.sv
// Table read and table write execution unit with pointer, latch and holding registers.
//
// Functional notes
// - A table read loads the program memory byte at the pointer into the table latch.
// - The table pointer is 21 bits wide and addresses program memory by byte over 2 Mbyte.
// - Pointer bit 0 picks the low byte (0) or the high byte (1) of a 16-bit word.
// - Read opcode 0000 0000 0000 10nn with nn 0 keep, 1 post-inc, 2 post-dec, 3 pre-inc.
// - A read takes two cycles: decode, then memory read in Q2 and latch write in Q4.
// - A table write copies the latch into the selected holding register, nn 0 keeps pointer.
// - Write opcode 0000 0000 0000 11nn uses the same four pointer actions as the read.
// - The three low pointer bits choose one of eight holding registers for a write.
// - Holding registers feed later programming and a table write never touches the array.
// - A table write leaves the N, OV, Z, DC and C status flags untouched.
`timescale 1ns/10ps
`default_nettype none
module program_memory_table_access (
  input  wire logic                                      mclk,
  input  wire logic                                      rst_n,
  input  wire logic                                      clk_en,
  input  wire logic [1:0]                                q_phase,
  input  wire table_access_pkg::instr_type               instr,
  input  wire logic                                      ptr_load,
  input  wire logic [table_access_pkg::PTR_W-1:0]        ptr_load_val,
  input  wire logic                                      latch_load,
  input  wire logic [table_access_pkg::DATA_W-1:0]       latch_load_val,
  input  wire logic [table_access_pkg::WORD_W-1:0]       mem_rdata,
  output table_access_pkg::mem_req_type                  mem_rd,
  output logic                                           busy,
  output logic                                           status_write_en,
  output logic [table_access_pkg::PTR_W-1:0]             table_pointer,
  output logic [table_access_pkg::DATA_W-1:0]            table_latch,
  output logic [table_access_pkg::HOLD_N*table_access_pkg::DATA_W-1:0] holding_data
);
  localparam int PW = table_access_pkg::PTR_W;
  localparam int DW = table_access_pkg::DATA_W;
  localparam logic [PW-1:0] ONE = 21'h000001;

  typedef enum logic [1:0] {IDLE, DECODE, EXEC} state_type;

  state_type state_q;
  state_type state_d;
  logic               is_wr_q;
  logic [1:0]         act_q;
  logic [PW-1:0]      ptr_q;
  logic [PW-1:0]      ptr_d;
  logic [DW-1:0]      latch_q;
  logic [DW-1:0]      latch_d;
  logic [DW-1:0]      hold_q [table_access_pkg::HOLD_N];
  logic [PW-1:0]      access_addr_q;
  logic [DW-1:0]      rd_byte_q;

  // Table operations share the upper thirteen bits; bit 2 then tells a write from a read.
  function automatic logic is_table_op(input logic [15:0] opc);
    return opc[15:3] == table_access_pkg::TBL_OPC_HI[13:1];
  endfunction

  wire logic          start     = clk_en && instr.valid && state_q == IDLE
                                  && is_table_op(instr.opcode) && q_phase == 2'h0;
  wire logic          at_dec_end = clk_en && state_q == DECODE
                                   && q_phase == table_access_pkg::Q_WRITE;
  wire logic          at_read   = clk_en && state_q == EXEC && q_phase == table_access_pkg::Q_READ;
  wire logic          at_write  = clk_en && state_q == EXEC && q_phase == table_access_pkg::Q_WRITE;
  wire logic [PW-1:0] ptr_inc   = PW'(ptr_q + ONE);
  wire logic [PW-1:0] ptr_dec   = PW'(ptr_q - ONE);
  wire logic          pre_inc   = act_q == table_access_pkg::ACT_PREINC;
  wire logic [PW-1:0] eff_addr  = pre_inc ? ptr_inc : ptr_q;
  wire logic [PW-1:0] post_ptr  = act_q == table_access_pkg::ACT_POSTINC ? ptr_inc :
                                  act_q == table_access_pkg::ACT_POSTDEC ? ptr_dec :
                                  pre_inc ? ptr_inc : ptr_q;
  wire logic [DW-1:0] sel_byte  = access_addr_q[0] ? mem_rdata[15:8] : mem_rdata[7:0];
  wire logic [2:0]    hold_sel  = access_addr_q[table_access_pkg::HOLD_SEL_W-1:0];

  always_comb begin
    state_d = state_q;
    ptr_d   = ptr_q;
    latch_d = latch_q;
    if (start) begin
      state_d = DECODE;
    end else if (at_dec_end) begin
      state_d = EXEC;
    end else if (at_write) begin
      state_d = IDLE;
      ptr_d   = post_ptr;
      if (!is_wr_q) begin
        latch_d = rd_byte_q;
      end
    end
    if (ptr_load && state_q == IDLE) begin
      ptr_d = ptr_load_val;
    end
    if (latch_load && state_q == IDLE) begin
      latch_d = latch_load_val;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= IDLE;
      is_wr_q       <= 1'b0;
      act_q         <= table_access_pkg::ACT_NONE;
      ptr_q         <= table_access_pkg::PTR_RESET;
      latch_q       <= table_access_pkg::LATCH_RESET;
      access_addr_q <= table_access_pkg::PTR_RESET;
      rd_byte_q     <= table_access_pkg::LATCH_RESET;
    end else if (clk_en) begin
      state_q <= state_d;
      ptr_q   <= ptr_d;
      latch_q <= latch_d;
      if (start) begin
        is_wr_q <= instr.opcode[2];
        act_q   <= instr.opcode[1:0];
      end
      if (state_q == EXEC && q_phase == 2'h0) begin
        access_addr_q <= eff_addr;
      end
      if (at_read && !is_wr_q) begin
        rd_byte_q <= sel_byte;
      end
    end
  end

  // Holding registers change only here and never drive a memory write.
  genvar gi;
  generate
    for (gi = 0; gi < table_access_pkg::HOLD_N; gi++) begin : g_hold
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          hold_q[gi] <= table_access_pkg::HOLD_RESET;
        end else if (at_write && is_wr_q && hold_sel == 3'(gi)) begin
          hold_q[gi] <= latch_q;
        end
      end
      assign holding_data[gi*DW +: DW] = hold_q[gi];
    end
  endgenerate

  assign mem_rd.req      = state_q == EXEC && !is_wr_q && q_phase == table_access_pkg::Q_READ;
  assign mem_rd.addr     = access_addr_q;
  assign busy            = state_q != IDLE;
  assign status_write_en = 1'b0;
  assign table_pointer   = ptr_q;
  assign table_latch     = latch_q;
endmodule : program_memory_table_access
`default_nettype wire

// ===== hdl/table_access_pkg.sv
// Package with constants and types for the program memory table access block.
package table_access_pkg;
  localparam int PTR_W      = 21;
  localparam int DATA_W     = 8;
  localparam int HOLD_N     = 8;
  localparam int HOLD_SEL_W = 3;
  localparam int WORD_W     = 16;
  localparam logic [13:0] TBL_OPC_HI  = 14'h0002;
  localparam logic [1:0]  ACT_NONE    = 2'h0;
  localparam logic [1:0]  ACT_POSTINC = 2'h1;
  localparam logic [1:0]  ACT_POSTDEC = 2'h2;
  localparam logic [1:0]  ACT_PREINC  = 2'h3;
  localparam logic [1:0]  Q_READ      = 2'h1;
  localparam logic [1:0]  Q_WRITE     = 2'h3;
  localparam logic [PTR_W-1:0]  PTR_RESET   = 21'h000000;
  localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [DATA_W-1:0] HOLD_RESET  = 8'hFF;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] opcode;
  } instr_type;

  typedef struct packed {
    logic             req;
    logic [PTR_W-1:0] addr;
  } mem_req_type;
endpackage : table_access_pkg

// ===== test/prog_mem_model.sv
// Program memory model that answers the word reads of the table access block.
`timescale 1ns/10ps
`default_nettype none
module prog_mem_model (
  input  wire table_access_pkg::mem_req_type mem_rd,
  output logic [15:0]                        mem_rdata
);
  assign mem_rdata = {8'h3C, 8'hA5} ^ {2{mem_rd.addr[8:1]}} ^ {16{!mem_rd.req}};
endmodule // prog_mem_model
`default_nettype wire

// ===== test/table_access_sva.sv
// Checker for the outputs of the table access block.
`timescale 1ns/10ps
`default_nettype none
module table_access_sva (
  input wire logic                          mclk,
  input wire logic                          rst_n,
  input wire table_access_pkg::mem_req_type mem_rd,
  input wire logic                          busy,
  input wire logic                          status_write_en,
  input wire logic [20:0]                   table_pointer,
  input wire logic [63:0]                   holding_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_flag; status_write_en == 1'h0; endproperty
  a_flag: assert property (p_flag) else $error("flags written");
  property p_req; mem_rd.req |-> busy; endproperty
  a_req: assert property (p_req) else $error("read outside execute");
  property p_once; mem_rd.req |=> !mem_rd.req [*3]; endproperty
  a_once: assert property (p_once) else $error("read repeated");
  property p_addr; mem_rd.req |-> mem_rd.addr - table_pointer <= 21'h1; endproperty
  a_addr: assert property (p_addr) else $error("read address");
  property p_ptr; $changed(table_pointer) |-> !$past(busy) || $fell(busy); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer moved early");
  property p_step; $fell(busy) |-> table_pointer - $past(table_pointer) + 21'h1 <= 21'h2; endproperty
  a_step: assert property (p_step) else $error("pointer step");
  property p_hold; $changed(holding_data) |-> $fell(busy); endproperty
  a_hold: assert property (p_hold) else $error("holding early");
  property p_end; $rose(mem_rd.req) |-> ##[1:3] $fell(busy); endproperty
  a_end: assert property (p_end) else $error("read end");
endmodule // table_access_sva
`default_nettype wire

// ===== test/test_program_memory_table_access.sv
// Testbench for the program memory table access block.
`timescale 1ns/10ps
`default_nettype none
module test_program_memory_table_access;
  logic                          mclk = 1'h0, rst_n = 1'h0, busy, status_write_en;
  logic [1:0]                    q_phase = 2'h0;
  logic [7:0]                    table_latch, el = 8'h00, llv = 8'h00;
  logic                          ll = 1'h0;
  logic [15:0]                   mem_rdata;
  logic [20:0]                   table_pointer, ep = 21'h0;
  logic [63:0]                   holding_data, eh = '1;
  int                            n_mismatch = 0, total_checks = 0;
  table_access_pkg::instr_type   instr = '0;
  table_access_pkg::mem_req_type mem_rd;
  wire logic [93:0]              seen = {busy, holding_data, table_latch, table_pointer};
  always #2 mclk = ~mclk;
  always @(posedge mclk) q_phase <= rst_n ? q_phase + 2'h1 : 2'h0;
  program_memory_table_access dut (.mclk, .rst_n, .clk_en(1'h1), .q_phase, .instr,
    .ptr_load(1'h0), .ptr_load_val(21'h0), .latch_load(ll), .latch_load_val(llv),
    .mem_rdata, .mem_rd, .busy, .status_write_en, .table_pointer, .table_latch, .holding_data);
  prog_mem_model mem (.mem_rd, .mem_rdata);
  task automatic op(input logic [15:0] o);
    logic        t;
    logic [20:0] a;
    t = o[15:3] === table_access_pkg::TBL_OPC_HI[13:1];
    a = ep + {20'h0, o[1:0] == 2'h3};
    do @(negedge mclk); while (q_phase !== 2'h3);
    @(posedge mclk) instr <= '{1'h1, o};
    @(posedge mclk) instr.valid <= 1'h0;
    repeat (9) @(negedge mclk);
    if (t && o[2]) eh[a[2:0]*8 +: 8] = el;
    if (t && !o[2]) el = a[8:1] ^ (a[0] ? 8'h3C : 8'hA5);
    if (t && o[1:0] != 2'h0) ep = o[1:0] == 2'h2 ? ep - 21'h1 : ep + 21'h1;
    total_checks++;
    if ({1'h0, eh, el, ep} !== seen) begin
      n_mismatch++;
      $display("unexpected state expected %h seen %h", {1'h0, eh, el, ep}, seen);
    end
  endtask
  task automatic t_read();
    op(16'h0010);
    op(16'h000A);
    op(16'h0009);
    op(16'h000B);
    op(16'h0008);
    $display("read test done");
  endtask
  task automatic t_write();
    @(posedge mclk) begin
      ll  <= 1'h1;
      llv <= 8'h5A;
    end
    @(posedge mclk) ll <= 1'h0;
    el = 8'h5A;
    op(16'h000F);
    op(16'h000D);
    op(16'h000C);
    op(16'h000E);
    $display("write test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    t_read();
    t_write();
    end_sim();
  end
  initial begin
    #4000 n_mismatch++;
    end_sim();
  end
endmodule // test_program_memory_table_access
bind program_memory_table_access table_access_sva sva (.mclk, .rst_n, .mem_rd, .busy,
  .status_write_en, .table_pointer, .holding_data);
`default_nettype wire
